// ==== dv/framer_props.sv ====
// Checker for framer bus, link and pin outputs.
// Assumes a bind onto radio_packet_framer.
`timescale 1ns/1ps
module framer_props (
  input wire logic              clk_i,
  input wire logic              rst_i,
  input wire logic [7:0]        wb_adr_i,
  input wire logic [31:0]       wb_dat_i,
  input wire logic [31:0]       wb_dat_o,
  input wire logic              wb_we_i,
  input wire logic [3:0]        wb_sel_i,
  input wire logic              wb_cyc_i,
  input wire logic              wb_stb_i,
  input wire logic              wb_ack_o,
  input wire framer_pkg::link_s tx_link_o,
  input wire framer_pkg::link_s rx_link_i,
  input wire logic              radio_tx_en_o,
  input wire logic              radio_rx_en_o,
  input wire logic              irq_o,
  input wire logic              irq_oe_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence req_s; wb_cyc_i && wb_stb_i && !wb_ack_o; endsequence
  sequence ans_s; wb_ack_o ##1 !wb_ack_o; endsequence
  a_bus_answer: assert property (req_s |=> ans_s)
    else $error("bus request not answered");
  a_no_stray: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
    else $error("ack without request");
  a_radio_excl: assert property (!(radio_tx_en_o && radio_rx_en_o))
    else $error("transmit and receive both on");
  a_send_in_tx: assert property (tx_link_o.valid |-> $past(radio_tx_en_o))
    else $error("bit sent outside transmit");
  a_bit_gap: assert property (tx_link_o.valid |=> (!tx_link_o.valid) [*8])
    else $error("bits too close");
  a_marker_next: assert property (tx_link_o.valid && tx_link_o.sop
    |-> ##[50:800] tx_link_o.valid) else $error("marker not followed");
  a_rate_legal: assert property (tx_link_o.valid |-> tx_link_o.rate != 2'h3)
    else $error("illegal rate");
  a_oe_driven: assert property (!$past(rst_i) |-> irq_oe_o)
    else $error("interrupt pin undriven");
endmodule

// ==== dv/peer_radio.sv ====
// Peer radio: decodes framer link bits and sends frames back.
// Assumes one valid pulse per bit and two marker bits per frame.
`timescale 1ns/1ps
module peer_radio (
  input  wire logic              clk_i,
  input  wire framer_pkg::link_s tx_link_i,
  output framer_pkg::link_s      rx_link_o
);
  logic [7:0] got[$], cur[$], sh;
  int         frames = 0;
  int         nb = 0;
  logic       busy = 1'b0;
  initial rx_link_o = '0;
  // Frame closes after length plus two checksum bytes.
  always @(posedge clk_i) begin
    if (!busy) rx_link_o <= {1'b0, ~rx_link_o.data, 3'h0};
    if (tx_link_i.valid && tx_link_i.sop) begin
      nb = 0;
      cur = {};
    end else if (tx_link_i.valid) begin
      sh = {sh[6:0], tx_link_i.data};
      nb++;
      if (nb % 8 == 0) cur.push_back(sh);
      if (cur.size() > 0 && cur.size() == int'(cur[0]) + 3) begin
        got = cur;
        frames++;
      end
    end
  end
  // Two marker bits of shared length, then bytes MSB first.
  task automatic send(input logic [7:0] q[$], input framer_pkg::rate_e rt, input int n);
    busy = 1'b1;
    for (int i = -2; i < 8 * q.size(); i++) begin
      for (int c = 0; c < n; c++) begin
        @(posedge clk_i);
        if (c == 0) rx_link_o <= {1'b1, i < 0 || q[i / 8][7 - i % 8], i < 0, rt};
        else rx_link_o <= {1'b0, ~rx_link_o.data, 1'b0, rt};
      end
    end
    @(posedge clk_i);
    busy = 1'b0;
  endtask
endmodule

// ==== dv/radio_packet_framer_bench.sv ====
// Bench: framer driven over Wishbone, peer radio on the link.
// Assumes package, framer, peer and checker compiled first.
`timescale 1ns/1ps
module radio_packet_framer_bench;
  logic              clk_i, rst_i, we, cyc, ack, irq;
  logic [7:0]        adr, q[$];
  logic [31:0]       wdat, rdat, r;
  logic [15:0]       sd;
  framer_pkg::link_s txl, rxl;
  integer            seed;
  int                bad_count = 0;
  int                checks = 0;
  radio_packet_framer uut (.clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(adr), .wb_dat_i(wdat),
    .wb_dat_o(rdat), .wb_we_i(we), .wb_sel_i(4'hF), .wb_cyc_i(cyc), .wb_stb_i(cyc),
    .wb_ack_o(ack), .tx_link_o(txl), .rx_link_i(rxl), .radio_tx_en_o(), .radio_rx_en_o(),
    .irq_o(irq), .irq_oe_o());
  peer_radio peer (.clk_i(clk_i), .tx_link_i(txl), .rx_link_o(rxl));
  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    {we, adr, wdat, cyc} <= {w, a, d, 1'b1};
    do @(posedge clk_i); while (ack !== 1'b1 && ++n < 20);
    r = rdat;
    cyc <= 1'b0;
    if (n >= 20) bad_count++;
    if (n >= 20) report_and_stop();
  endtask
  task automatic poll(input int b, input int f);
    for (int n = 0; n < 9000 && r[b] !== 1'b1 && peer.frames < f; n++)
      wb(1'b0, framer_pkg::ADDR_STATUS, 32'h0);
    chk(r[b] === 1'b1 || peer.frames >= f, 1'b1);
    if (bad_count > 0) report_and_stop();
  endtask
  function automatic logic [15:0] crc16(input logic [7:0] p[$], input logic [15:0] s);
    foreach (p[i]) for (int b = 7; b >= 0; b--)
      s = (s << 1) ^ ((s[15] ^ p[i][b]) ? framer_pkg::CRC_POLY : 16'h0000);
    return s;
  endfunction
  task automatic mk(inout logic [7:0] p[$], input logic [15:0] c);
    p.push_front(8'(p.size()));
    p.push_back(c[15:8]);
    p.push_back(c[7:0]);
  endtask
  task automatic fchk(input logic [7:0] p[$]);
    mk(p, crc16(p, sd));
    chk(peer.got.size(), p.size());
    foreach (p[i]) chk(peer.got[i], p[i]);
  endtask
  task automatic rx_send(input logic [7:0] p[$], input logic [15:0] c,
                         input framer_pkg::rate_e rt, input int n);
    mk(p, c);
    peer.send(p, rt, n);
  endtask
  initial begin
    seed = 32'hA5D0;
    rst_i = 1'b1;
    {we, cyc, adr, wdat, r} = '0;
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(1'b0, framer_pkg::ADDR_CFG, 32'h0);
    chk(r, 32'(framer_pkg::CFG_RESET));
    wb(1'b0, 8'h3C, 32'h0);
    chk(r, 32'h0);
    sd = 16'($random(seed));
    wb(1'b1, framer_pkg::ADDR_SEED, 32'(sd));
    wb(1'b1, framer_pkg::ADDR_CFG, 32'h68);
    wb(1'b1, framer_pkg::ADDR_IRQ_EN, 32'h3);
    // Data first, then length, then launch.
    q = '{8'($random(seed)), 8'($random(seed)), 8'($random(seed))};
    foreach (q[i]) wb(1'b1, framer_pkg::ADDR_TX_DATA, 32'(q[i]));
    wb(1'b1, framer_pkg::ADDR_TX_LEN, 32'h3);
    wb(1'b1, framer_pkg::ADDR_CTRL, 32'h1);
    poll(0, 1);
    fchk(q);
    rx_send('{}, 16'h0, framer_pkg::RATE_GFSK, 50);
    poll(framer_pkg::ST_TX_DONE, 99);
    chk(r[framer_pkg::ST_ACK_TO], 1'b0);
    wb(1'b1, framer_pkg::ADDR_STATUS, 32'hFF);
    wb(1'b1, framer_pkg::ADDR_CTRL, 32'h2);
    q = '{8'($random(seed)), 8'($random(seed))};
    rx_send(q, crc16(q, sd), framer_pkg::RATE_S32, 200);
    poll(framer_pkg::ST_RX_DONE, 99);
    @(posedge clk_i);
    chk(irq, 1'b1);
    poll(31, 2);
    fchk('{});
    wb(1'b0, framer_pkg::ADDR_RX_LEN, 32'h0);
    chk(r, 32'h2);
    foreach (q[i]) begin
      wb(1'b0, framer_pkg::ADDR_RX_DATA, 32'h0);
      chk(r, 32'(q[i]));
    end
    wb(1'b1, framer_pkg::ADDR_STATUS, 32'hFF);
    wb(1'b1, framer_pkg::ADDR_CTRL, 32'h2);
    rx_send(q, crc16(q, sd) ^ 16'h0001, framer_pkg::RATE_S64, 400);
    poll(framer_pkg::ST_CRC_ERR, 99);
    chk(r[framer_pkg::ST_RX_DONE], 1'b0);
    report_and_stop();
  end
endmodule
bind radio_packet_framer framer_props u_props (.clk_i(clk_i), .rst_i(rst_i),
  .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_we_i(wb_we_i),
  .wb_sel_i(wb_sel_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o),
  .tx_link_o(tx_link_o), .rx_link_i(rx_link_i), .radio_tx_en_o(radio_tx_en_o),
  .radio_rx_en_o(radio_rx_en_o), .irq_o(irq_o), .irq_oe_o(irq_oe_o));

// ==== src/framer_pkg.sv ====
// Package for the radio packet framer and transaction sequencer.
// Assumes a 50 MHz system clock and a classic Wishbone register master.
package framer_pkg;

  // ----------------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL    = 8'h00;
  localparam logic [7:0] ADDR_CFG     = 8'h04;
  localparam logic [7:0] ADDR_SEED    = 8'h08;
  localparam logic [7:0] ADDR_TX_LEN  = 8'h0C;
  localparam logic [7:0] ADDR_TX_DATA = 8'h10;
  localparam logic [7:0] ADDR_RX_DATA = 8'h14;
  localparam logic [7:0] ADDR_STATUS  = 8'h18;
  localparam logic [7:0] ADDR_IRQ_EN  = 8'h1C;
  localparam logic [7:0] ADDR_RX_LEN  = 8'h20;

  // ----------------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------------
  localparam int CTRL_TX_GO    = 0;
  localparam int CTRL_RX_GO    = 1;
  localparam int CTRL_ABORT    = 2;
  localparam int CFG_SPREAD    = 0;
  localparam int CFG_CODE64    = 1;
  localparam int CFG_SOP64     = 2;
  localparam int CFG_CRC_EN    = 3;
  localparam int CFG_ZERO_SEED = 4;
  localparam int CFG_AUTO_ACK  = 5;
  localparam int CFG_IRQ_POL   = 6;
  localparam int CFG_IRQ_GPIO  = 7;
  localparam int CFG_GPIO_VAL  = 8;
  localparam int CFG_THREE_W   = 9;
  localparam int CFG_W         = 10;

  localparam logic [CFG_W-1:0] CFG_RESET = 10'h020;
  localparam logic [15:0]      SEED_RESET = 16'h0000;

  // Status bits: rx done, crc error, tx done, ack timeout, tx fifo low,
  // rx fifo not empty, rx overflow, busy.
  localparam int ST_RX_DONE  = 0;
  localparam int ST_CRC_ERR  = 1;
  localparam int ST_TX_DONE  = 2;
  localparam int ST_ACK_TO   = 3;
  localparam int ST_TX_LOW   = 4;
  localparam int ST_RX_AVAIL = 5;
  localparam int ST_RX_OVF   = 6;
  localparam int ST_BUSY     = 7;
  localparam int ST_W        = 8;

  // ----------------------------------------------------------------------
  // Buffer and framing constants
  // ----------------------------------------------------------------------
  localparam int FIFO_DEPTH = 16;
  localparam int FIFO_AW    = 4;
  localparam int SOP_SYMS   = 2;
  localparam int CRC_BYTES  = 2;
  localparam int MAX_LEN    = 40;
  localparam logic [15:0] CRC_POLY = 16'h8005;
  localparam logic [7:0]  ACK_LEN  = 8'h00;
  localparam logic [4:0]  TX_LOW_MARK = 5'h08;

  // ----------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------
  localparam int CLK_HZ        = 50_000_000;
  localparam int RATE_GFSK_KBPS = 1000;
  localparam int RATE_32_KBPS   = 250;
  localparam int RATE_64_KBPS   = 125;
  localparam int CYC_BIT_GFSK  = CLK_HZ / (RATE_GFSK_KBPS * 1000);
  localparam int CYC_BIT_32    = CLK_HZ / (RATE_32_KBPS * 1000);
  localparam int CYC_BIT_64    = CLK_HZ / (RATE_64_KBPS * 1000);
  localparam int SYNTH_US      = 100;
  localparam int SYNTH_CYC     = SYNTH_US * (CLK_HZ / 1_000_000);
  localparam int ACK_WAIT_US   = 2000;
  localparam int ACK_WAIT_CYC  = ACK_WAIT_US * (CLK_HZ / 1_000_000);
  localparam int TIMER_W       = 20;

  typedef enum logic [1:0] {
    RATE_GFSK,
    RATE_S32,
    RATE_S64
  } rate_e;

  // Serial link towards the modem: one bit per baud enable.
  typedef struct packed {
    logic  valid;
    logic  data;
    logic  sop;
    rate_e rate;
  } link_s;

endpackage

// ==== src/radio_packet_framer.sv ====
// Radio baseband framer with packet buffers and transaction sequencer.
// Assumes a bit-serial modem link carrying framed symbols, bus on Wishbone.
//
// The Wishbone register port and the placing of the registers were left to the implementer.
`timescale 1ns/1ps

module radio_packet_framer (
  input  wire logic                 clk_i,
  input  wire logic                 rst_i,
  input  wire logic [7:0]           wb_adr_i,
  input  wire logic [31:0]          wb_dat_i,
  output logic      [31:0]          wb_dat_o,
  input  wire logic                 wb_we_i,
  input  wire logic [3:0]           wb_sel_i,
  input  wire logic                 wb_cyc_i,
  input  wire logic                 wb_stb_i,
  output logic                      wb_ack_o,
  output framer_pkg::link_s         tx_link_o,
  input  wire framer_pkg::link_s    rx_link_i,
  output logic                      radio_tx_en_o,
  output logic                      radio_rx_en_o,
  output logic                      irq_o,
  output logic                      irq_oe_o
);

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  typedef enum logic [3:0] {
    S_IDLE, S_SETTLE, S_TX_SOP, S_TX_LEN, S_TX_BODY, S_TX_CRC,
    S_ACK_WAIT, S_RX_LISTEN, S_RX_LEN, S_RX_BODY, S_RX_CRC, S_ACK_SEND
  } seq_e;

  seq_e                           seq_q;
  logic [framer_pkg::CFG_W-1:0]   cfg_q;
  logic [15:0]                    seed_q;
  logic [7:0]                     tx_len_q;
  logic [7:0]                     rx_len_q;
  logic [framer_pkg::ST_W-1:0]    st_q;
  logic [framer_pkg::ST_W-1:0]    irq_en_q;
  logic [7:0]                     txf_mem [framer_pkg::FIFO_DEPTH];
  logic [7:0]                     rxf_mem [framer_pkg::FIFO_DEPTH];
  logic [framer_pkg::FIFO_AW:0]   txf_wp_q, txf_rp_q, rxf_wp_q, rxf_rp_q;
  logic [4:0]                     txf_cnt, rxf_cnt;
  logic [framer_pkg::TIMER_W-1:0] tmr_q, baud_q;
  logic [7:0]                     sh_q;
  logic [2:0]                     bit_q;
  logic [7:0]                     bytes_q;
  logic [15:0]                    crc_q, crc0_q, rx_crc_q;
  logic                           ack_mode_q;
  logic                           wb_ack_q;
  logic [31:0]                    rdata_q;

  wire logic wb_req  = wb_cyc_i && wb_stb_i && !wb_ack_q;
  wire logic wb_wr   = wb_req && wb_we_i && wb_sel_i[0];
  wire logic wb_rd   = wb_req && !wb_we_i;

  assign txf_cnt = 5'(txf_wp_q - txf_rp_q);
  assign rxf_cnt = 5'(rxf_wp_q - rxf_rp_q);

  // One CRC step per bit, polynomial x16+x15+x2+1.
  function automatic logic [15:0] crc_step(input logic [15:0] c, input logic b);
    crc_step = (c[15] ^ b) ? ((c << 1) ^ framer_pkg::CRC_POLY) : (c << 1);
  endfunction

  // Bit period of a rate in clock cycles.
  function automatic logic [framer_pkg::TIMER_W-1:0] bit_cyc(input framer_pkg::rate_e r);
    case (r)
      framer_pkg::RATE_S32: bit_cyc = framer_pkg::TIMER_W'(framer_pkg::CYC_BIT_32);
      framer_pkg::RATE_S64: bit_cyc = framer_pkg::TIMER_W'(framer_pkg::CYC_BIT_64);
      default:              bit_cyc = framer_pkg::TIMER_W'(framer_pkg::CYC_BIT_GFSK);
    endcase
  endfunction

  // ----------------------------------------------------------------------
  // Rate selection
  // ----------------------------------------------------------------------
  // mode to rate
  framer_pkg::rate_e tx_rate;
  always_comb begin
    if (!cfg_q[framer_pkg::CFG_SPREAD]) begin
      tx_rate = framer_pkg::RATE_GFSK;
    end else if (cfg_q[framer_pkg::CFG_CODE64]) begin
      tx_rate = framer_pkg::RATE_S64;
    end else begin
      tx_rate = framer_pkg::RATE_S32;
    end
  end

  framer_pkg::rate_e sop_rate;
  assign sop_rate = cfg_q[framer_pkg::CFG_SOP64] ? framer_pkg::RATE_S64 : framer_pkg::RATE_S32;

  wire logic is_tx   = (seq_q == S_TX_SOP) || (seq_q == S_TX_LEN) ||
                       (seq_q == S_TX_BODY) || (seq_q == S_TX_CRC);
  wire logic is_rx   = (seq_q == S_RX_LISTEN) || (seq_q == S_RX_LEN) ||
                       (seq_q == S_RX_BODY) || (seq_q == S_RX_CRC) || (seq_q == S_ACK_WAIT);
  wire logic baud    = is_tx && (baud_q == '0);
  wire logic rx_bit  = rx_link_i.valid && !rx_link_i.sop && is_rx;
  wire logic byte_end = bit_q == 3'h7;
  wire logic crc_on  = cfg_q[framer_pkg::CFG_CRC_EN];
  wire logic body_done = bytes_q == (ack_mode_q ? framer_pkg::ACK_LEN : tx_len_q);
  wire logic tx_load = byte_end && !ack_mode_q &&
                       ((seq_q == S_TX_LEN && !body_done) ||
                        (seq_q == S_TX_BODY && bytes_q + 8'h01 != tx_len_q));
  wire logic tx_pop  = baud && tx_load;
  wire logic tx_need = tx_load && txf_cnt == 5'h00;
  wire logic [15:0] crc_nx = (seq_q == S_TX_BODY) ? crc_step(crc_q, sh_q[7]) : crc_q;

  wire logic rx_body_done = bytes_q == rx_len_q;
  wire logic [7:0] rx_byte = {sh_q[6:0], rx_link_i.data};
  wire logic [15:0] rx_crc_fin = {rx_crc_q[14:0], rx_link_i.data};
  wire logic crc_ok = !crc_on || (rx_crc_fin == crc_q) || (rx_crc_fin == crc0_q);
  wire logic rx_store = rx_bit && byte_end && (seq_q == S_RX_BODY) && !ack_mode_q;
  wire logic rx_end = rx_bit && (seq_q == S_RX_CRC || (seq_q == S_RX_BODY && !crc_on)) &&
                      (seq_q == S_RX_CRC ? (byte_end && bytes_q == 8'(framer_pkg::CRC_BYTES - 1))
                                          : (byte_end && bytes_q == 8'(rx_len_q - 8'h01)));

  // ----------------------------------------------------------------------
  // Baud timer for the transmit bit periods
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i || !is_tx || baud_q == '0) begin
      baud_q <= (seq_q == S_TX_SOP) ? bit_cyc(sop_rate) - 1'b1 : bit_cyc(tx_rate) - 1'b1;
    end else begin
      baud_q <= baud_q - 1'b1;
    end
  end

  // ----------------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      seq_q      <= S_IDLE;
      tmr_q      <= '0;
      bit_q      <= '0;
      bytes_q    <= '0;
      sh_q       <= '0;
      crc_q      <= '0;
      crc0_q     <= '0;
      rx_crc_q   <= '0;
      ack_mode_q <= 1'b0;
      rx_len_q   <= '0;
    end else if (wb_wr && wb_adr_i == framer_pkg::ADDR_CTRL && wb_dat_i[framer_pkg::CTRL_ABORT]) begin
      seq_q <= S_IDLE;
    end else begin
      case (seq_q)
        S_IDLE: begin
          ack_mode_q <= 1'b0;
          if (wb_wr && wb_adr_i == framer_pkg::ADDR_CTRL && wb_dat_i[framer_pkg::CTRL_TX_GO]) begin
            seq_q <= S_SETTLE;
            tmr_q <= framer_pkg::TIMER_W'(framer_pkg::SYNTH_CYC);
          end else if (wb_wr && wb_adr_i == framer_pkg::ADDR_CTRL &&
                       wb_dat_i[framer_pkg::CTRL_RX_GO]) begin
            seq_q <= S_RX_LISTEN;
          end
        end
        S_SETTLE: begin
          bit_q   <= '0;
          bytes_q <= '0;
          tmr_q   <= tmr_q - 1'b1;
          crc_q   <= cfg_q[framer_pkg::CFG_ZERO_SEED] ? 16'h0000 : seed_q;
          if (tmr_q == '0) begin
            seq_q <= S_TX_SOP;
          end
        end
        S_TX_SOP: if (baud) begin
          bit_q <= 3'(bit_q + 1'b1);
          if (bit_q == 3'(framer_pkg::SOP_SYMS - 1)) begin
            bit_q <= '0;
            seq_q <= S_TX_LEN;
            sh_q  <= ack_mode_q ? framer_pkg::ACK_LEN : tx_len_q;
          end
        end
        S_TX_LEN, S_TX_BODY, S_TX_CRC: if (baud && !tx_need) begin
          bit_q <= 3'(bit_q + 1'b1);
          sh_q  <= {sh_q[6:0], 1'b0};
          crc_q <= crc_nx;
          if (byte_end) begin
            if (seq_q == S_TX_BODY) begin
              bytes_q <= bytes_q + 8'h01;
            end
            if (seq_q == S_TX_CRC) begin
              bytes_q <= bytes_q + 8'h01;
              sh_q    <= crc_q[7:0];
              if (bytes_q == 8'(framer_pkg::CRC_BYTES - 1)) begin
                seq_q <= ack_mode_q ? S_RX_LISTEN : S_ACK_WAIT;
                tmr_q <= framer_pkg::TIMER_W'(framer_pkg::ACK_WAIT_CYC);
              end
            end else if ((seq_q == S_TX_LEN && body_done) ||
                         (seq_q == S_TX_BODY && bytes_q + 8'h01 == tx_len_q)) begin
              seq_q   <= crc_on ? S_TX_CRC : (ack_mode_q ? S_RX_LISTEN : S_ACK_WAIT);
              bytes_q <= '0;
              sh_q    <= crc_nx[15:8];
              crc_q   <= crc_nx;
              tmr_q   <= framer_pkg::TIMER_W'(framer_pkg::ACK_WAIT_CYC);
            end else begin
              seq_q <= S_TX_BODY;
              sh_q  <= txf_mem[txf_rp_q[framer_pkg::FIFO_AW-1:0]];
            end
          end
        end
        S_ACK_WAIT: begin
          tmr_q <= tmr_q - 1'b1;
          if (rx_link_i.valid && rx_link_i.sop) begin
            seq_q <= S_IDLE;
          end else if (tmr_q == '0) begin
            seq_q <= S_IDLE;
          end
        end
        S_RX_LISTEN: if (rx_link_i.valid && rx_link_i.sop) begin
          seq_q    <= S_RX_LEN;
          bit_q    <= '0;
          bytes_q  <= '0;
          crc_q    <= seed_q;
          crc0_q   <= 16'h0000;
          ack_mode_q <= 1'b0;
        end
        S_RX_LEN, S_RX_BODY, S_RX_CRC: if (rx_bit) begin
          bit_q <= 3'(bit_q + 1'b1);
          sh_q  <= rx_byte;
          if (seq_q == S_RX_CRC) begin
            rx_crc_q <= rx_crc_fin;
          end else if (seq_q == S_RX_BODY) begin
            crc_q  <= crc_step(crc_q, rx_link_i.data);
            crc0_q <= crc_step(crc0_q, rx_link_i.data);
          end
          if (byte_end) begin
            bytes_q <= bytes_q + 8'h01;
            if (seq_q == S_RX_LEN) begin
              rx_len_q <= rx_byte;
              bytes_q  <= '0;
              seq_q    <= (rx_byte == 8'h00) ? (crc_on ? S_RX_CRC : S_RX_LISTEN) : S_RX_BODY;
            end else if (seq_q == S_RX_BODY && bytes_q + 8'h01 == rx_len_q && crc_on) begin
              seq_q   <= S_RX_CRC;
              bytes_q <= '0;
            end
          end
          if (rx_end) begin
            if (crc_ok && cfg_q[framer_pkg::CFG_AUTO_ACK] && rx_len_q != framer_pkg::ACK_LEN) begin
              seq_q      <= S_SETTLE;
              ack_mode_q <= 1'b1;
              tmr_q      <= framer_pkg::TIMER_W'(framer_pkg::SYNTH_CYC);
            end else begin
              seq_q <= S_RX_LISTEN;
            end
          end
        end
        S_ACK_SEND: seq_q <= S_IDLE;
        default: seq_q <= S_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Packet buffers
  // ----------------------------------------------------------------------
  // buffers, acks bypass
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      txf_wp_q <= '0;
      txf_rp_q <= '0;
    end else begin
      if (wb_wr && wb_adr_i == framer_pkg::ADDR_TX_DATA && txf_cnt != 5'(framer_pkg::FIFO_DEPTH)) begin
        txf_mem[txf_wp_q[framer_pkg::FIFO_AW-1:0]] <= wb_dat_i[7:0];
        txf_wp_q <= txf_wp_q + 1'b1;
      end
      if (tx_pop && txf_cnt != 5'h00 && !tx_need) begin
        txf_rp_q <= txf_rp_q + 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rxf_wp_q <= '0;
      rxf_rp_q <= '0;
    end else begin
      if (rx_store && rxf_cnt != 5'(framer_pkg::FIFO_DEPTH)) begin
        rxf_mem[rxf_wp_q[framer_pkg::FIFO_AW-1:0]] <= rx_byte;
        rxf_wp_q <= rxf_wp_q + 1'b1;
      end
      if (wb_rd && wb_adr_i == framer_pkg::ADDR_RX_DATA && rxf_cnt != 5'h00) begin
        rxf_rp_q <= rxf_rp_q + 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Status flags
  // ----------------------------------------------------------------------
  logic [framer_pkg::ST_W-1:0] ev;
  always_comb begin
    ev = '0;
    ev[framer_pkg::ST_RX_DONE] = rx_end && crc_ok && !ack_mode_q;
    ev[framer_pkg::ST_CRC_ERR] = rx_end && !crc_ok;
    ev[framer_pkg::ST_ACK_TO]  = (seq_q == S_ACK_WAIT) && tmr_q == '0 &&
                                 !(rx_link_i.valid && rx_link_i.sop);
    ev[framer_pkg::ST_TX_DONE] = (seq_q == S_ACK_WAIT) && rx_link_i.valid && rx_link_i.sop;
    ev[framer_pkg::ST_RX_OVF]  = rx_store && rxf_cnt == 5'(framer_pkg::FIFO_DEPTH);
  end

  // Set wins over a write-one-to-clear in the same cycle.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_q <= '0;
    end else begin
      st_q <= ev | (st_q & ~((wb_wr && wb_adr_i == framer_pkg::ADDR_STATUS) ?
                             wb_dat_i[framer_pkg::ST_W-1:0] : '0));
      st_q[framer_pkg::ST_TX_LOW]   <= txf_cnt <= framer_pkg::TX_LOW_MARK;
      st_q[framer_pkg::ST_RX_AVAIL] <= rxf_cnt != 5'h00;
      st_q[framer_pkg::ST_BUSY]     <= seq_q != S_IDLE;
    end
  end

  // ----------------------------------------------------------------------
  // Register slave
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cfg_q    <= framer_pkg::CFG_RESET;
      seed_q   <= framer_pkg::SEED_RESET;
      tx_len_q <= '0;
      irq_en_q <= '0;
    end else if (wb_wr) begin
      case (wb_adr_i)
        framer_pkg::ADDR_CFG:    cfg_q    <= wb_dat_i[framer_pkg::CFG_W-1:0];
        framer_pkg::ADDR_SEED:   seed_q   <= wb_dat_i[15:0];
        framer_pkg::ADDR_TX_LEN: tx_len_q <= wb_dat_i[7:0];
        framer_pkg::ADDR_IRQ_EN: irq_en_q <= wb_dat_i[framer_pkg::ST_W-1:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_q <= 1'b0;
      rdata_q  <= '0;
    end else begin
      wb_ack_q <= wb_req;
      case (wb_adr_i)
        framer_pkg::ADDR_CFG:     rdata_q <= 32'(cfg_q);
        framer_pkg::ADDR_SEED:    rdata_q <= 32'(seed_q);
        framer_pkg::ADDR_TX_LEN:  rdata_q <= 32'(tx_len_q);
        framer_pkg::ADDR_RX_DATA: rdata_q <= 32'(rxf_mem[rxf_rp_q[framer_pkg::FIFO_AW-1:0]]);
        framer_pkg::ADDR_STATUS:  rdata_q <= 32'(st_q);
        framer_pkg::ADDR_IRQ_EN:  rdata_q <= 32'(irq_en_q);
        framer_pkg::ADDR_RX_LEN:  rdata_q <= 32'(rx_len_q);
        default:                  rdata_q <= 32'h0000_0000;
      endcase
    end
  end

  assign wb_ack_o = wb_ack_q;
  assign wb_dat_o = rdata_q;

  // ----------------------------------------------------------------------
  // Link and pins
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tx_link_o <= '0;
      irq_o     <= 1'b0;
      irq_oe_o  <= 1'b0;
    end else begin
      tx_link_o.valid <= baud && !tx_need;
      tx_link_o.sop   <= seq_q == S_TX_SOP;
      tx_link_o.data  <= (seq_q == S_TX_SOP) ? 1'b1 : sh_q[7];
      tx_link_o.rate  <= (seq_q == S_TX_SOP) ? sop_rate : tx_rate;
      irq_oe_o <= 1'b1;
      irq_o    <= cfg_q[framer_pkg::CFG_IRQ_GPIO] ? cfg_q[framer_pkg::CFG_GPIO_VAL] :
                  ((|(st_q & irq_en_q)) ~^ cfg_q[framer_pkg::CFG_IRQ_POL]);
    end
  end

  assign radio_tx_en_o = is_tx;
  assign radio_rx_en_o = is_rx;

endmodule
